// ---- design/fscr_regs.svh ----
// Bit positions, reset values and timing of the flash status/config regs
`ifndef FSCR_REGS_SVH
`define FSCR_REGS_SVH

`define FSCR_ST_BUSY_LO   0
`define FSCR_ST_WEL       1
`define FSCR_ST_ERS_SUSP  2
`define FSCR_ST_PRG_SUSP  3
`define FSCR_ST_LOCKDOWN  4
`define FSCR_ST_SEC_LOCK  5
`define FSCR_ST_RES6      6
`define FSCR_ST_BUSY_HI   7

`define FSCR_CF_PIN_USAGE 1
`define FSCR_CF_VOLATIL   3
`define FSCR_CF_PIN_EN    7

`define FSCR_BYTE_ZERO    8'h00
`define FSCR_CNT_ZERO     16'h0000
`define FSCR_CNT_ONE      16'h0001

`define FSCR_CLK_NS       50
`define FSCR_T_PROTECT_PIN_ENABLE_NS    1000

`endif

// ---- design/fscr_pkg.sv ----
// Types shared by the flash status/config register block
package fscr_pkg;

  typedef enum logic [3:0] {
    FSCR_NOP,
    FSCR_WRITE_ENABLE,
    FSCR_WRITE_DISABLE,
    FSCR_SOFT_RESET,
    FSCR_SUSPEND,
    FSCR_RESUME,
    FSCR_PROGRAM,
    FSCR_QUAD_PROGRAM,
    FSCR_ERASE,
    FSCR_PROT_WRITE,
    FSCR_LOCKDOWN_PROT,
    FSCR_CFG_WRITE,
    FSCR_SECID_PROGRAM,
    FSCR_SECID_LOCKOUT,
    FSCR_PERM_LOCK,
    FSCR_QUAD_READ
  } fscr_cmd_code_t;

  typedef struct packed {
    fscr_cmd_code_t code;
    logic [7:0]     data;
  } fscr_cmd_t;

  typedef struct packed {
    logic      valid;
    fscr_cmd_t cmd;
  } fscr_go_t;

endpackage

// ---- design/fscr_top.sv ----
// Status and configuration registers of a serial flash, two clock domains
// Notes on behaviour
// - Status byte is read only; host writes never alter it.
// - Busy flag appears at both bit 0 and bit 7.
// - Latch clear rejects program, erase, protection write and lock-down.
// - Latch clears on reset, disable, suspend, register writes, op completion.
// - Erase-suspended bit sets on suspend during erase, clears on resume.
// - Program-suspended bit sets on suspend during program, clears on resume.
// - Lock-down bit sets on lock-down command; only power cycle clears it.
// - Security-locked bit sets on lockout and persists across power-ups.
// - Status bit 6 always reads zero.
// - Config byte readable and writable; bits 0,2,4,5,6 read zero.
// - Config bit 1 selects protect/pause pins or quad data lines.
// - Quad SPI reads and quad program invalid unless config bit 1 set or full quad command mode is on.
// - In full quad command mode the pin-usage bit has no effect on quad command checks or hardware protection.
// - Pin-usage power-up value depends on factory variant.
// - Volatility bit reads one until any permanent lock bit is set.
// - Pin-enable bit is nonvolatile, factory zero, keeps last value.
// - Hardware protection only when protect pin low and enable set.
// - Changing the pin-enable value starts a timed write that raises busy.
// - Hardware protection blocks only protection and config writes.
// - Quad pin usage overrides the pin-enable bit.
// - Lock-down refuses every protection register change until power cycle.
`include "fscr_regs.svh"

module fscr_top #(
  parameter bit PIN_USAGE_INIT = 1'b0,
  parameter int T_PROTECT_PIN_ENABLE_NS      = `FSCR_T_PROTECT_PIN_ENABLE_NS
) (
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  input  wire logic              sck,
  input  wire logic              cmd_valid,
  input  wire fscr_pkg::fscr_cmd_t cmd_in,
  input  wire logic              full_quad_command_mode,
  input  wire logic              protect_pin_n,
  input  wire logic              array_busy,
  input  wire logic              array_done,
  input  wire logic              nv_sec_locked,
  input  wire logic              nv_pin_enable,
  input  wire logic              nv_perm_locked,
  output logic [7:0]             rd_status,
  output logic [7:0]             rd_config,
  output fscr_pkg::fscr_go_t     op_go,
  output logic                   cmd_reject,
  output logic                   hw_protect,
  output logic                   quad_pins,
  output logic                   nv_pin_enable_wr,
  output logic                   nv_pin_enable_val,
  output logic                   nv_sec_lock_wr
);

  localparam int PROTECT_PIN_ENABLE_CYC_I =
    (T_PROTECT_PIN_ENABLE_NS + `FSCR_CLK_NS - 1) / `FSCR_CLK_NS;
  localparam logic [15:0] PROTECT_PIN_ENABLE_CYC =
    (PROTECT_PIN_ENABLE_CYC_I < 1) ? `FSCR_CNT_ONE : 16'(PROTECT_PIN_ENABLE_CYC_I);

  // Link domain: hold the command and flip a toggle per command
  fscr_pkg::fscr_cmd_t hold_q;
  logic                tog_q;

  always_ff @(posedge sck or negedge rstn) begin
    if (!rstn) begin
      hold_q <= '0;
      tog_q  <= 1'b0;
    end else if (cmd_valid) begin
      hold_q <= cmd_in;
      tog_q  <= ~tog_q;
    end
  end

  // System domain: command toggle crossing
  logic tog_s1_q;
  logic tog_s2_q;
  logic tog_s3_q;
  logic quad_s1_q;
  logic quad_s2_q;
  logic wp_s1_q;
  logic wp_s2_q;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tog_s1_q  <= 1'b0;
      tog_s2_q  <= 1'b0;
      tog_s3_q  <= 1'b0;
      quad_s1_q <= 1'b0;
      quad_s2_q <= 1'b0;
      wp_s1_q   <= 1'b1;
      wp_s2_q   <= 1'b1;
    end else begin
      tog_s1_q  <= tog_q;
      tog_s2_q  <= tog_s1_q;
      tog_s3_q  <= tog_s2_q;
      quad_s1_q <= full_quad_command_mode;
      quad_s2_q <= quad_s1_q;
      wp_s1_q   <= protect_pin_n;
      wp_s2_q   <= wp_s1_q;
    end
  end

  // Hold stays stable for many sys cycles after the toggle, so it is safe
  logic                take;
  fscr_pkg::fscr_cmd_t cmd;
  assign take = tog_s2_q ^ tog_s3_q;
  assign cmd  = hold_q;

  // Register state
  logic        wel_q;
  logic        ers_susp_q;
  logic        prg_susp_q;
  logic        lockdown_q;
  logic        sec_q;
  logic        busy_q;
  logic        erase_run_q;
  logic        pin_usage_q;
  logic        pin_en_q;
  logic        perm_lock_q;
  logic        loaded_q;
  logic [15:0] protect_pin_enable_cnt_q;

  logic quad_ok;
  logic hwp;
  logic gated;
  logic reject;
  logic ok;
  assign quad_ok = pin_usage_q | quad_s2_q;
  assign hwp = ~wp_s2_q & pin_en_q & ~pin_usage_q & ~quad_s2_q;

  always_comb begin
    gated = 1'b0;
    case (cmd.code)
      fscr_pkg::FSCR_PROGRAM,
      fscr_pkg::FSCR_QUAD_PROGRAM,
      fscr_pkg::FSCR_ERASE,
      fscr_pkg::FSCR_PROT_WRITE,
      fscr_pkg::FSCR_LOCKDOWN_PROT,
      fscr_pkg::FSCR_SECID_PROGRAM,
      fscr_pkg::FSCR_SECID_LOCKOUT,
      fscr_pkg::FSCR_PERM_LOCK: gated = 1'b1;
      default: gated = 1'b0;
    endcase
  end

  always_comb begin
    reject = 1'b0;
    if (gated && !wel_q) begin
      reject = 1'b1;
    end
    if (busy_q && (gated || cmd.code == fscr_pkg::FSCR_CFG_WRITE)) begin
      reject = 1'b1;
    end
    case (cmd.code)
      fscr_pkg::FSCR_QUAD_PROGRAM,
      fscr_pkg::FSCR_QUAD_READ: if (!quad_ok) reject = 1'b1;
      fscr_pkg::FSCR_PROT_WRITE: begin
        if (lockdown_q || hwp) reject = 1'b1;
      end
      fscr_pkg::FSCR_PERM_LOCK: if (lockdown_q) reject = 1'b1;
      fscr_pkg::FSCR_CFG_WRITE: if (hwp) reject = 1'b1;
      default: ;
    endcase
  end
  assign ok = take & ~reject;

  // Write-enable latch: completion of an array op clears it as well
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wel_q <= 1'b0;
    end else if (ok) begin
      case (cmd.code)
        fscr_pkg::FSCR_WRITE_ENABLE:  wel_q <= 1'b1;
        fscr_pkg::FSCR_WRITE_DISABLE,
        fscr_pkg::FSCR_SOFT_RESET,
        fscr_pkg::FSCR_SUSPEND,
        fscr_pkg::FSCR_PROT_WRITE,
        fscr_pkg::FSCR_LOCKDOWN_PROT,
        fscr_pkg::FSCR_CFG_WRITE:     wel_q <= 1'b0;
        default: if (array_done) wel_q <= 1'b0;
      endcase
    end else if (array_done) begin
      wel_q <= 1'b0;
    end
  end

  // Suspend flags and the kind of array op that runs
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ers_susp_q  <= 1'b0;
      prg_susp_q  <= 1'b0;
      erase_run_q <= 1'b0;
    end else begin
      if (ok && cmd.code == fscr_pkg::FSCR_ERASE) begin
        erase_run_q <= 1'b1;
      end else if (ok && gated) begin
        erase_run_q <= 1'b0;
      end
      if (ok && cmd.code == fscr_pkg::FSCR_SUSPEND && busy_q) begin
        if (erase_run_q) begin
          ers_susp_q <= 1'b1;
        end else begin
          prg_susp_q <= 1'b1;
        end
      end else if (ok && cmd.code == fscr_pkg::FSCR_RESUME) begin
        ers_susp_q <= 1'b0;
        prg_susp_q <= 1'b0;
      end
    end
  end

  // Lock flags; nonvolatile ones are reloaded right after reset release
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lockdown_q  <= 1'b0;
      sec_q       <= 1'b0;
      perm_lock_q <= 1'b0;
      loaded_q    <= 1'b0;
    end else begin
      loaded_q <= 1'b1;
      if (!loaded_q) begin
        sec_q       <= nv_sec_locked;
        perm_lock_q <= nv_perm_locked;
      end else begin
        if (ok && cmd.code == fscr_pkg::FSCR_SECID_LOCKOUT) begin
          sec_q <= 1'b1;
        end
        if (ok && cmd.code == fscr_pkg::FSCR_PERM_LOCK &&
            cmd.data != `FSCR_BYTE_ZERO) begin
          perm_lock_q <= 1'b1;
        end
      end
      if (ok && cmd.code == fscr_pkg::FSCR_LOCKDOWN_PROT) begin
        lockdown_q <= 1'b1;
      end
    end
  end

  // Config bits: only pin usage and pin enable are writable
  logic wr_cfg;
  logic pin_en_chg;
  assign wr_cfg = ok && cmd.code == fscr_pkg::FSCR_CFG_WRITE;
  assign pin_en_chg = wr_cfg && cmd.data[`FSCR_CF_PIN_EN] != pin_en_q;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pin_usage_q <= PIN_USAGE_INIT;
      pin_en_q    <= 1'b0;
    end else if (!loaded_q) begin
      pin_en_q    <= nv_pin_enable;
    end else if (wr_cfg) begin
      pin_usage_q <= cmd.data[`FSCR_CF_PIN_USAGE];
      pin_en_q    <= cmd.data[`FSCR_CF_PIN_EN];
    end
  end

  // Self-timed write of the nonvolatile pin enable keeps busy high
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      protect_pin_enable_cnt_q <= `FSCR_CNT_ZERO;
    end else if (pin_en_chg) begin
      protect_pin_enable_cnt_q <= PROTECT_PIN_ENABLE_CYC;
    end else if (protect_pin_enable_cnt_q != `FSCR_CNT_ZERO) begin
      protect_pin_enable_cnt_q <= protect_pin_enable_cnt_q - `FSCR_CNT_ONE;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= array_busy | pin_en_chg |
                (protect_pin_enable_cnt_q > `FSCR_CNT_ONE);
    end
  end

  // Register images; host writes reach them only through the flags
  logic [7:0] status_w;
  logic [7:0] config_w;
  always_comb begin
    status_w = `FSCR_BYTE_ZERO;
    status_w[`FSCR_ST_BUSY_LO]  = busy_q;
    status_w[`FSCR_ST_BUSY_HI]  = busy_q;
    status_w[`FSCR_ST_WEL]      = wel_q;
    status_w[`FSCR_ST_ERS_SUSP] = ers_susp_q;
    status_w[`FSCR_ST_PRG_SUSP] = prg_susp_q;
    status_w[`FSCR_ST_LOCKDOWN] = lockdown_q;
    status_w[`FSCR_ST_SEC_LOCK] = sec_q;
    config_w = `FSCR_BYTE_ZERO;
    config_w[`FSCR_CF_PIN_USAGE] = pin_usage_q;
    config_w[`FSCR_CF_VOLATIL]   = ~perm_lock_q;
    config_w[`FSCR_CF_PIN_EN]    = pin_en_q;
  end

  // System-domain outputs
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      op_go             <= '0;
      cmd_reject        <= 1'b0;
      hw_protect        <= 1'b0;
      quad_pins         <= PIN_USAGE_INIT;
      nv_pin_enable_wr  <= 1'b0;
      nv_pin_enable_val <= 1'b0;
      nv_sec_lock_wr    <= 1'b0;
    end else begin
      op_go.valid       <= ok && (gated ||
                           cmd.code == fscr_pkg::FSCR_QUAD_READ);
      op_go.cmd         <= cmd;
      cmd_reject        <= take && reject;
      hw_protect        <= hwp;
      quad_pins         <= pin_usage_q;
      nv_pin_enable_wr  <= pin_en_chg;
      nv_pin_enable_val <= cmd.data[`FSCR_CF_PIN_EN];
      nv_sec_lock_wr    <= ok &&
                           cmd.code == fscr_pkg::FSCR_SECID_LOCKOUT;
    end
  end

  // Read images cross to the link clock bit by bit; each is a slow level
  logic [7:0] st_s1_q;
  logic [7:0] cf_s1_q;
  always_ff @(posedge sck or negedge rstn) begin
    if (!rstn) begin
      st_s1_q   <= `FSCR_BYTE_ZERO;
      cf_s1_q   <= `FSCR_BYTE_ZERO;
      rd_status <= `FSCR_BYTE_ZERO;
      rd_config <= `FSCR_BYTE_ZERO;
    end else begin
      st_s1_q   <= status_w;
      cf_s1_q   <= config_w;
      rd_status <= st_s1_q;
      rd_config <= cf_s1_q;
    end
  end

  // Checks in the system domain
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_cfg_pin_en_write;
    wr_cfg && cmd.data[`FSCR_CF_PIN_EN] != pin_en_q;
  endsequence

  sequence s_erase_suspend;
    ok && cmd.code == fscr_pkg::FSCR_SUSPEND && busy_q && erase_run_q;
  endsequence

  property p_busy_mirror;
    status_w[`FSCR_ST_BUSY_LO] == status_w[`FSCR_ST_BUSY_HI];
  endproperty
  a_busy_mirror: assert property (p_busy_mirror)
    else $error("busy bits differ");

  property p_reserved_zero;
    !status_w[`FSCR_ST_RES6] && (config_w & 8'h75) == `FSCR_BYTE_ZERO;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bit set");

  property p_wel_gate;
    take && gated && !wel_q |=> cmd_reject && !op_go.valid;
  endproperty
  a_wel_gate: assert property (p_wel_gate)
    else $error("gated command taken without latch");

  property p_wel_clear;
    take && cmd.code == fscr_pkg::FSCR_WRITE_DISABLE |=> !wel_q;
  endproperty
  a_wel_clear: assert property (p_wel_clear)
    else $error("latch not cleared by disable");

  property p_lockdown_sticky;
    lockdown_q |=> lockdown_q;
  endproperty
  a_lockdown_sticky: assert property (p_lockdown_sticky)
    else $error("lock-down flag dropped");

  property p_sec_sticky;
    sec_q |=> sec_q ##1 sec_q;
  endproperty
  a_sec_sticky: assert property (p_sec_sticky)
    else $error("security lock dropped");

  property p_quad_reject;
    take && cmd.code == fscr_pkg::FSCR_QUAD_READ && !quad_ok
      |=> cmd_reject;
  endproperty
  a_quad_reject: assert property (p_quad_reject)
    else $error("quad command accepted without pin usage");

  property p_pin_en_busy;
    s_cfg_pin_en_write |=> status_w[`FSCR_ST_BUSY_LO] [*2];
  endproperty
  a_pin_en_busy: assert property (p_pin_en_busy)
    else $error("busy not raised by pin enable write");

  property p_erase_suspend;
    s_erase_suspend |=> ers_susp_q && !prg_susp_q;
  endproperty
  a_erase_suspend: assert property (p_erase_suspend)
    else $error("erase suspend not flagged");

  property p_hwp_blocks_cfg;
    take && cmd.code == fscr_pkg::FSCR_CFG_WRITE && hwp
      |=> $stable(pin_en_q) && $stable(pin_usage_q);
  endproperty
  a_hwp_blocks_cfg: assert property (p_hwp_blocks_cfg)
    else $error("config changed under hardware protection");

endmodule

// ---- bench/fscr_host_model.sv ----
// Host-side serial controller model: decoded commands and register polls
module fscr_host_model (
  output logic                sck,
  output logic                cmd_valid,
  output fscr_pkg::fscr_cmd_t cmd_in,
  input  wire logic [7:0]     rd_status,
  input  wire logic [7:0]     rd_config
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    sck = 1'b0;
    cmd_valid = 1'b0;
    cmd_in = '0;
  end

  // The serial clock only runs inside a frame
  task automatic tick(input int n);
    repeat (n) begin
      #7.5 sck = 1'b1;
      #7.5 sck = 1'b0;
    end
  endtask

  // Spacing of 24 cycles keeps the unacknowledged hold register safe
  task automatic send(input fscr_pkg::fscr_cmd_code_t c,
                      input logic [7:0] d);
    cmd_in.code = c;
    cmd_in.data = d;
    cmd_valid = 1'b1;
    tick(1);
    cmd_valid = 1'b0;
    cmd_in.data = ~d;
    tick(24);
  endtask

  // One poll: four serial clocks, then a single sample of status and config
  task automatic poll(output logic [7:0] st, output logic [7:0] cf);
    tick(4);
    st = rd_status;
    cf = rd_config;
  endtask
endmodule

// ---- bench/flash_status_config_regs_test.sv ----
// Self-checking bench for the flash status and configuration registers
module flash_status_config_regs_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic                 clk_sys = 1'b0;
  logic                 rstn = 1'b0;
  logic                 sck;
  logic                 cmd_valid;
  fscr_pkg::fscr_cmd_t  cmd_in;
  logic                 full_quad_command_mode = 1'b0;
  logic                 protect_pin_n = 1'b1;
  logic                 array_busy = 1'b0;
  logic                 array_done = 1'b0;
  logic                 nv_sec_locked = 1'b0;
  logic                 nv_pin_enable = 1'b0;
  logic                 nv_perm_locked = 1'b0;
  logic [7:0]           rd_status;
  logic [7:0]           rd_config;
  fscr_pkg::fscr_go_t   op_go;
  logic                 cmd_reject;
  logic                 hw_protect;
  logic                 quad_pins;
  logic                 nv_pin_enable_wr;
  logic                 nv_pin_enable_val;
  logic                 nv_sec_lock_wr;
  int                   miscompares = 0;
  int                   samples_checked = 0;
  int                   n_go = 0;
  int                   n_rej = 0;
  int                   n_pw = 0;
  int                   n_sl = 0;
  logic [3:0]           last_go = 4'h0;

  fscr_top #(.PIN_USAGE_INIT(1'b0), .T_PROTECT_PIN_ENABLE_NS(100)) i_dut (
    .clk_sys, .rstn, .sck, .cmd_valid, .cmd_in, .full_quad_command_mode,
    .protect_pin_n, .array_busy, .array_done, .nv_sec_locked,
    .nv_pin_enable, .nv_perm_locked, .rd_status, .rd_config, .op_go,
    .cmd_reject, .hw_protect, .quad_pins, .nv_pin_enable_wr,
    .nv_pin_enable_val, .nv_sec_lock_wr
  );

  fscr_host_model i_host (
    .sck, .cmd_valid, .cmd_in, .rd_status, .rd_config
  );

  always #25 clk_sys = ~clk_sys;

  // One-cycle pulses are counted here so no poll can miss them
  always @(posedge clk_sys) begin
    if (op_go.valid === 1'b1) begin
      n_go++;
      last_go = op_go.cmd.code;
    end
    if (cmd_reject === 1'b1) n_rej++;
    if (nv_pin_enable_wr === 1'b1) n_pw++;
    if (nv_sec_lock_wr === 1'b1) n_sl++;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic cmd(input fscr_pkg::fscr_cmd_code_t c,
                     input logic [7:0] d, input int go, input int rej);
    int g0;
    int r0;
    g0 = n_go;
    r0 = n_rej;
    i_host.send(c, d);
    if (go >= 0) chk(8'(n_go - g0), 8'(go));
    chk(8'(n_rej - r0), 8'(rej));
  endtask

  task automatic st(input logic [7:0] es, input logic [7:0] ec);
    logic [7:0] s;
    logic [7:0] c;
    cyc(2);
    i_host.poll(s, c);
    chk(s, es);
    chk(c, ec);
  endtask

  // Sync inputs move only on the falling clock edge, clear of the sampling one
  task automatic done_pulse();
    cyc(1);
    array_done = 1'b1;
    cyc(1);
    array_done = 1'b0;
    array_busy = 1'b0;
  endtask

  // sck must also toggle while reset is held
  task automatic do_reset();
    cyc(1);
    rstn = 1'b0;
    cyc(8);
    i_host.tick(3);
    cyc(1);
    rstn = 1'b1;
    cyc(4);
  endtask

  task automatic t_gate();
    i_host.send(fscr_pkg::FSCR_WRITE_DISABLE, 8'h00);
    cmd(fscr_pkg::FSCR_PROGRAM, 8'h00, 0, 1);
    cmd(fscr_pkg::FSCR_ERASE, 8'h00, 0, 1);
    cmd(fscr_pkg::FSCR_PROT_WRITE, 8'h00, 0, 1);
    cmd(fscr_pkg::FSCR_LOCKDOWN_PROT, 8'h00, 0, 1);
    i_host.send(fscr_pkg::FSCR_WRITE_ENABLE, 8'h00);
    st(8'h02, 8'h08);
    i_host.send(fscr_pkg::FSCR_WRITE_DISABLE, 8'h00);
    st(8'h00, 8'h08);
  endtask

  task automatic t_susp(input fscr_pkg::fscr_cmd_code_t c,
                        input logic [7:0] flag);
    i_host.send(fscr_pkg::FSCR_WRITE_ENABLE, 8'h00);
    cmd(c, 8'h00, 1, 0);
    chk(8'(last_go), 8'(c));
    cyc(1);
    array_busy = 1'b1;
    st(8'h83, 8'h08);
    i_host.send(fscr_pkg::FSCR_SUSPEND, 8'h00);
    cyc(1);
    array_busy = 1'b0;
    st(flag, 8'h08);
    i_host.send(fscr_pkg::FSCR_RESUME, 8'h00);
    cyc(1);
    array_busy = 1'b1;
    st(8'h81, 8'h08);
    done_pulse();
    st(8'h00, 8'h08);
  endtask

  task automatic t_cfg();
    int p0;
    p0 = n_pw;
    cmd(fscr_pkg::FSCR_CFG_WRITE, 8'hff, 0, 0);
    st(8'h00, 8'h8a);
    chk(8'(n_pw - p0), 8'h01);
    chk(8'(nv_pin_enable_val), 8'h01);
    chk(8'(quad_pins), 8'h01);
    cyc(1);
    protect_pin_n = 1'b0;
    cyc(4);
    chk(8'(hw_protect), 8'h00);
    cmd(fscr_pkg::FSCR_CFG_WRITE, 8'h80, 0, 0);
    st(8'h00, 8'h88);
    chk(8'(hw_protect), 8'h01);
    cmd(fscr_pkg::FSCR_CFG_WRITE, 8'h00, 0, 1);
    cmd(fscr_pkg::FSCR_QUAD_READ, 8'h00, 0, 1);
    cyc(1);
    full_quad_command_mode = 1'b1;
    cyc(4);
    cmd(fscr_pkg::FSCR_QUAD_READ, 8'h00, -1, 0);
    cyc(1);
    full_quad_command_mode = 1'b0;
    i_host.send(fscr_pkg::FSCR_WRITE_ENABLE, 8'h00);
    cmd(fscr_pkg::FSCR_PROT_WRITE, 8'h00, 0, 1);
    cmd(fscr_pkg::FSCR_PROGRAM, 8'h00, 1, 0);
    done_pulse();
    cyc(1);
    protect_pin_n = 1'b1;
    cyc(4);
    chk(8'(hw_protect), 8'h00);
    cmd(fscr_pkg::FSCR_CFG_WRITE, 8'h02, 0, 0);
    cmd(fscr_pkg::FSCR_QUAD_READ, 8'h00, -1, 0);
  endtask

  task automatic t_lock();
    int s0;
    s0 = n_sl;
    i_host.send(fscr_pkg::FSCR_WRITE_ENABLE, 8'h00);
    cmd(fscr_pkg::FSCR_LOCKDOWN_PROT, 8'h00, 1, 0);
    st(8'h10, 8'h0a);
    i_host.send(fscr_pkg::FSCR_WRITE_ENABLE, 8'h00);
    cmd(fscr_pkg::FSCR_PROT_WRITE, 8'h00, 0, 1);
    i_host.send(fscr_pkg::FSCR_WRITE_ENABLE, 8'h00);
    cmd(fscr_pkg::FSCR_SECID_LOCKOUT, 8'h00, 1, 0);
    chk(8'(n_sl - s0), 8'h01);
    done_pulse();
    st(8'h30, 8'h0a);
    cyc(1);
    nv_sec_locked = 1'b1;
    nv_perm_locked = 1'b1;
    nv_pin_enable = 1'b1;
    do_reset();
    st(8'h20, 8'h80);
    chk(8'(quad_pins), 8'h00);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #2ms;
    miscompares++;
    final_report();
  end

  initial begin
    do_reset();
    st(8'h00, 8'h08);
    chk(8'(hw_protect), 8'h00);
    t_gate();
    t_susp(fscr_pkg::FSCR_ERASE, 8'h04);
    t_susp(fscr_pkg::FSCR_PROGRAM, 8'h08);
    t_cfg();
    t_lock();
    final_report();
  end
endmodule
